/* File: rps_pkg.sv */
package rps_pkg;

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    localparam int ADDR_W           = 3;
    localparam int ADDR_BIT0        = 0;
    localparam int ADDR_BIT1        = 1;
    localparam int ADDR_BIT2        = 2;
    localparam int BCR_ISOLATE_BIT  = 10;
    localparam int BCR_W            = 16;
    localparam int CAPTURE_DELAY    = 3;
    localparam logic [1:0] CAP_CNT_RST = 2'h0;

    // ------------------------------------------------------------
    // Reference clock
    // ------------------------------------------------------------
    localparam int    CLK_MHZ        = 200;
    localparam int    REFCLK_MHZ     = 50;
    localparam int    REFCLK_HALF    = CLK_MHZ / (2 * REFCLK_MHZ);
    localparam int    DIV_W          = 4;
    localparam logic [3:0] DIV_RST   = 4'h0;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    localparam logic [2:0] SYNC_RST_LO = 3'h0;
    localparam logic [2:0] SYNC_RST_HI = 3'h7;

    typedef enum {
        RPS_ST_RESET,
        RPS_ST_CAPTURE,
        RPS_ST_RUN
    } rps_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] phy_addr;
        logic              duplex;
        logic              cfg_bit0;
        logic              cfg_bit2;
        logic              bcast_disable;
        logic              isolate;
        logic              nand_tree_n;
    } rps_straps_t;

    localparam rps_straps_t STRAPS_RST = '{phy_addr: 3'h1, duplex: 1'b1, cfg_bit0: 1'b0,
                                           cfg_bit2: 1'b0, bcast_disable: 1'b0, isolate: 1'b0,
                                           nand_tree_n: 1'b1};

    typedef struct packed {
        logic       crs_dv;
        logic [1:0] rxd;
        logic       rx_er;
    } rps_rx_t;

    typedef struct packed {
        logic       tx_en;
        logic [1:0] txd;
    } rps_tx_t;

endpackage

/* File: rps_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_ce,
    input  wire logic i_async,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    // ------------------------------------------------------------
    // Three stage synchroniser with agreement filter
    // ------------------------------------------------------------
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       level;
    logic       next_level;

    always_comb
    begin
        next_stage = stage;
        next_level = level;
        if (i_ce)
        begin
            next_stage = {stage[1:0], i_async};
            if (stage[1] == stage[2])
            begin
                next_level = stage[2];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            stage <= RST_VAL ? rps_pkg::SYNC_RST_HI : rps_pkg::SYNC_RST_LO;
            level <= RST_VAL;
        end
        else
        begin
            stage <= next_stage;
            level <= next_level;
        end
    end

    assign o_level = level;
    assign o_rise  = i_ce && (stage[1] == stage[2]) && stage[2] && !level;
    assign o_fall  = i_ce && (stage[1] == stage[2]) && !stage[2] && level;
endmodule
`default_nettype wire

/* File: rps_top.sv */
// What this block does
// [RULE_01] Address strap bit 0 pin captured as PHY address bit 0 at reset release.
// [RULE_02] Address strap bit 1 pin captured as PHY address bit 1 at reset release.
// [RULE_03] RXD1 pin captured as address bit 2, then drives receive data bit 1.
// [RULE_04] RXD0 pin captured as duplex, then drives receive data bit 0.
// [RULE_05] CRS_DV pin captured as config bit 2, then drives CRS_DV.
// [RULE_06] Dedicated config strap pin captured as config bit 0 at reset release.
// [RULE_07] In 25 MHz mode, generate and drive a 50 MHz reference clock.
// [RULE_08] In 50 MHz mode, never drive the reference clock pin.
// [RULE_09] Surroundings supply a 25 MHz clock on the clock input in 25 MHz mode.
// [RULE_10] Reference clock pin captured as broadcast-off setting at reset release.
// [RULE_11] RXER pin captured as isolate, then drives receive error.
// [RULE_12] Interrupt pin is open-drain, driven low only when interrupt is requested.
// [RULE_13] Interrupt pin captured as NAND-tree mode setting at reset release.
// [RULE_14] MAC drives TXEN, TXD0 and TXD1 into the device.
// [RULE_15] Management master drives MDC; MDIO is open-drain and synchronous to MDC.
// [RULE_16] Strap pins are inputs only during reset, outputs otherwise. Code: refclk driven only in 25 MHz mode, interrupt only on request.
// [RULE_17] High broadcast-off makes address 0 unique; low makes it broadcast.
// [RULE_18] High isolate strap enables isolate; value loads control register bit 10.
// [RULE_19] Low NAND-tree strap enables NAND-tree mode; high disables it.
// [RULE_20] Captured straps hold until the next reset whatever the pins do.
`timescale 1ns/1ps
`default_nettype none
module rps_top #(
    parameter int ADDR_W = rps_pkg::ADDR_W
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_nrst,
    input  wire logic                          i_ce,
    input  wire logic                          i_mode_50mhz,
    input  wire logic                          i_addr_strap_bit0,
    input  wire logic                          i_addr_strap_bit1,
    input  wire logic                          i_cfg_strap_bit0,
    input  wire logic                          i_rxd1_in,
    output logic                               o_rxd1_out,
    output logic                               o_rxd1_oe,
    input  wire logic                          i_rxd0_in,
    output logic                               o_rxd0_out,
    output logic                               o_rxd0_oe,
    input  wire logic                          i_crs_dv_in,
    output logic                               o_crs_dv_out,
    output logic                               o_crs_dv_oe,
    input  wire logic                          i_refclk_in,
    output logic                               o_refclk_out,
    output logic                               o_refclk_oe,
    input  wire logic                          i_rx_er_in,
    output logic                               o_rx_er_out,
    output logic                               o_rx_er_oe,
    input  wire logic                          i_irq_out_n_in,
    output logic                               o_irq_out_n_out,
    output logic                               o_irq_out_n_oe,
    input  wire rps_pkg::rps_rx_t              i_rx,
    input  wire logic                          i_irq_req,
    input  wire rps_pkg::rps_tx_t              i_tx,
    output rps_pkg::rps_tx_t                   o_tx,
    input  wire logic                          i_mdc,
    input  wire logic                          i_mdio_in,
    input  wire logic                          i_mdio_drive_low,
    output logic                               o_mdio_out,
    output logic                               o_mdio_oe,
    output logic                               o_mdc_level,
    output logic                               o_mdc_rise,
    output logic                               o_mdio_level,
    output rps_pkg::rps_straps_t               o_straps,
    output logic [ADDR_W-1:0]                  o_mgmt_phy_address,
    output logic                               o_addr0_broadcast,
    output logic                               o_isolate_en,
    output logic                               o_nand_tree_en,
    output logic [rps_pkg::BCR_W-1:0]          o_bcr_strap_bits,
    output logic                               o_run
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 12;
    localparam logic [NSYNC-1:0] SYNC_INIT = 12'h0;

    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] lvl;
    logic [NSYNC-1:0] rise;

    assign raw = {i_mdio_in, i_mdc, i_irq_out_n_in, i_rx_er_in, i_refclk_in, i_crs_dv_in,
                  i_rxd0_in, i_rxd1_in, i_cfg_strap_bit0, i_addr_strap_bit1, i_addr_strap_bit0,
                  i_mode_50mhz};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_sync
            rps_sync #(
                .RST_VAL (SYNC_INIT[g])
            ) u_sync (
                .i_clk   (i_clk),
                .i_nrst  (i_nrst),
                .i_ce    (i_ce),
                .i_async (raw[g]),
                .o_level (lvl[g]),
                .o_rise  (rise[g]),
                .o_fall  ()
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Capture sequencer
    // ------------------------------------------------------------
    rps_pkg::rps_state_t  state;
    rps_pkg::rps_state_t  next_state;
    logic [1:0]           cap_cnt;
    logic [1:0]           next_cap_cnt;
    rps_pkg::rps_straps_t straps;
    rps_pkg::rps_straps_t next_straps;
    logic                 mode_50;
    logic                 next_mode_50;

    always_comb
    begin
        next_state   = state;
        next_cap_cnt = cap_cnt;
        next_straps  = straps;
        next_mode_50 = mode_50;
        if (i_ce)
        begin
            case (state)
                rps_pkg::RPS_ST_RESET:
                begin
                    next_state = rps_pkg::RPS_ST_CAPTURE;
                end
                rps_pkg::RPS_ST_CAPTURE:
                begin
                    next_cap_cnt = cap_cnt + 2'h1;
                    if (cap_cnt == 2'(rps_pkg::CAPTURE_DELAY))
                    begin
                        next_straps.phy_addr[rps_pkg::ADDR_BIT0] = lvl[1];   // see [RULE_01]
                        next_straps.phy_addr[rps_pkg::ADDR_BIT1] = lvl[2];   // see [RULE_02]
                        next_straps.cfg_bit0      = lvl[3];                   // see [RULE_06]
                        next_straps.phy_addr[rps_pkg::ADDR_BIT2] = lvl[4];   // see [RULE_03]
                        next_straps.duplex        = lvl[5];                   // see [RULE_04]
                        next_straps.cfg_bit2      = lvl[6];                   // see [RULE_05]
                        next_straps.bcast_disable = lvl[7];                   // see [RULE_10]
                        next_straps.isolate       = lvl[8];                   // see [RULE_11]
                        next_straps.nand_tree_n   = lvl[9];                   // see [RULE_13]
                        next_mode_50              = lvl[0];
                        next_state                = rps_pkg::RPS_ST_RUN;
                    end
                end
                rps_pkg::RPS_ST_RUN:
                begin
                    next_state = rps_pkg::RPS_ST_RUN;                         // see [RULE_20]
                end
                default:
                begin
                    next_state = rps_pkg::RPS_ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state   <= rps_pkg::RPS_ST_RESET;
            cap_cnt <= rps_pkg::CAP_CNT_RST;
            straps  <= rps_pkg::STRAPS_RST;
            mode_50 <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            cap_cnt <= next_cap_cnt;
            straps  <= next_straps;
            mode_50 <= next_mode_50;
        end
    end

    // ------------------------------------------------------------
    // Reference clock divider
    // ------------------------------------------------------------
    logic [rps_pkg::DIV_W-1:0] div_cnt;
    logic [rps_pkg::DIV_W-1:0] next_div_cnt;
    logic                      refclk;
    logic                      next_refclk;
    logic                      run;

    assign run = (state == rps_pkg::RPS_ST_RUN);

    always_comb
    begin
        next_div_cnt = div_cnt;
        next_refclk  = refclk;
        if (i_ce && run && !mode_50)                                          // see [RULE_07]
        begin
            if (div_cnt == rps_pkg::DIV_W'(rps_pkg::REFCLK_HALF - 1))
            begin
                next_div_cnt = rps_pkg::DIV_RST;
                next_refclk  = !refclk;
            end
            else
            begin
                next_div_cnt = div_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            div_cnt <= rps_pkg::DIV_RST;
            refclk  <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            refclk  <= next_refclk;
        end
    end

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    rps_pkg::rps_rx_t rx_q;
    rps_pkg::rps_rx_t next_rx_q;
    logic             irq_q;
    logic             next_irq_q;

    always_comb
    begin
        next_rx_q  = rx_q;
        next_irq_q = irq_q;
        if (i_ce)
        begin
            next_rx_q  = run ? i_rx : '0;
            next_irq_q = run && i_irq_req;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rx_q  <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            rx_q  <= next_rx_q;
            irq_q <= next_irq_q;
        end
    end

    assign o_rxd1_out      = rx_q.rxd[1];                                    // see [RULE_03]
    assign o_rxd1_oe       = run;                                             // see [RULE_16]
    assign o_rxd0_out      = rx_q.rxd[0];                                    // see [RULE_04]
    assign o_rxd0_oe       = run;                                             // see [RULE_16]
    assign o_crs_dv_out    = rx_q.crs_dv;                                    // see [RULE_05]
    assign o_crs_dv_oe     = run;                                             // see [RULE_16]
    assign o_rx_er_out     = rx_q.rx_er;                                     // see [RULE_11]
    assign o_rx_er_oe      = run;                                             // see [RULE_16]
    assign o_refclk_out    = refclk;                                          // see [RULE_07]
    assign o_refclk_oe     = run && !mode_50;                                 // see [RULE_08]
    assign o_irq_out_n_out = 1'b0;                                            // see [RULE_12]
    assign o_irq_out_n_oe  = irq_q;                                           // see [RULE_12]
    assign o_tx            = i_tx;                                            // see [RULE_14]
    assign o_mdio_out      = 1'b0;                                            // see [RULE_15]
    assign o_mdio_oe       = run && i_mdio_drive_low;                         // see [RULE_15]
    assign o_mdc_level     = lvl[10];                                         // see [RULE_15]
    assign o_mdc_rise      = rise[10];
    assign o_mdio_level    = lvl[11];
    assign o_run           = run;

    // ------------------------------------------------------------
    // Decoded settings
    // ------------------------------------------------------------
    always_comb
    begin
        o_bcr_strap_bits = '0;
        o_bcr_strap_bits[rps_pkg::BCR_ISOLATE_BIT] = straps.isolate;          // see [RULE_18]
    end

    assign o_straps           = straps;
    assign o_mgmt_phy_address = straps.phy_addr;
    assign o_addr0_broadcast  = !straps.bcast_disable;                        // see [RULE_17]
    assign o_isolate_en       = straps.isolate;                               // see [RULE_18]
    assign o_nand_tree_en     = !straps.nand_tree_n;                          // see [RULE_19]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_straps_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_20]
        $past(run) && run |-> $stable(straps))
        else $error("straps changed after capture");
    a_addr0_capture: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_01]
        $rose(run) |-> straps.phy_addr[0] == $past(lvl[1]))
        else $error("address bit 0 not captured");
    a_addr1_capture: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_02]
        $rose(run) |-> straps.phy_addr[1] == $past(lvl[2]))
        else $error("address bit 1 not captured");
    a_addr2_capture: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_03]
        $rose(run) |-> straps.phy_addr[2] == $past(lvl[4]))
        else $error("address bit 2 not captured");
    a_duplex_capture: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_04]
        $rose(run) |-> straps.duplex == $past(lvl[5]))
        else $error("duplex not captured");
    a_cfg_capture: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_05]
        $rose(run) |-> straps.cfg_bit2 == $past(lvl[6]) && straps.cfg_bit0 == $past(lvl[3]))
        else $error("config bits not captured");
    a_bcast_capture: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_10]
        $rose(run) |-> straps.bcast_disable == $past(lvl[7]))
        else $error("broadcast-off not captured");
    a_iso_capture: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_11]
        $rose(run) |-> straps.isolate == $past(lvl[8]) && o_bcr_strap_bits[10] == straps.isolate)
        else $error("isolate not captured");
    a_nand_capture: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_13]
        $rose(run) |-> o_nand_tree_en == !$past(lvl[9]))
        else $error("nand tree not captured");
    a_refclk_off: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_08]
        mode_50 |-> !o_refclk_oe)
        else $error("refclk driven in 50 MHz mode");
    a_refclk_toggle: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_07]
        (i_ce && run && !mode_50)[*2] |=> refclk != $past(refclk, 2))
        else $error("refclk not 50 MHz");
    a_strap_input: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_16]
        !run |-> !o_rxd1_oe && !o_rxd0_oe && !o_crs_dv_oe && !o_rx_er_oe && !o_irq_out_n_oe)
        else $error("strap pin driven before run");
    a_irq_drain: assert property (@(posedge i_clk) disable iff (!i_nrst) // see [RULE_12]
        i_ce && run && i_irq_req |=> o_irq_out_n_oe && !o_irq_out_n_out)
        else $error("interrupt not pulled low");
endmodule
`default_nettype wire

/* File: rps_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rps_mac_model (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_frame,
    output rps_pkg::rps_tx_t o_tx,
    output logic             o_mdc,
    output logic             o_mdio_low,
    output logic             o_done
);
    // ------------------------------------------------------------
    // Transmit side, new value after each rising clock edge
    // ------------------------------------------------------------
    always @(posedge i_clk)
    begin
        o_tx <= i_nrst ? rps_pkg::rps_tx_t'($urandom) : '0;
    end
    // ------------------------------------------------------------
    // Management clock runs only inside a frame
    // ------------------------------------------------------------
    initial
    begin
        o_mdc = 1'b0;
        o_mdio_low = 1'b0;
        o_done = 1'b0;
        forever
        begin
            #3.3;
            if (i_frame && !o_done)
            begin
                repeat (8)
                begin
                    #32 o_mdc = 1'b1;
                    #32 o_mdc = 1'b0;
                    o_mdio_low = 1'($urandom);
                end
                o_mdio_low = 1'b0;
                o_done = 1'b1;
            end
            else if (!i_frame)
                o_done = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb_rps_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_rps_top;
    logic                 clk, nrst, ce, mode, irq, drv, frame, done, mac_low, mdc;
    rps_pkg::rps_straps_t s, st, held;
    rps_pkg::rps_rx_t     rx, v;
    rps_pkg::rps_tx_t     tx, txo;
    logic                 d1o, d1e, d0o, d0e, cro, cre, rfo, rfe, ero, ere, iro, ire;
    logic                 mdo, mde, mdl, mdr, mil, run, bc, iso, nand_en, prev;
    logic [2:0]           addr;
    logic [15:0]          bcr;
    wire logic            mdio = ~((mde & ~mdo) | mac_low);
    int                   errors, checks, rises, i, r, t;

    rps_mac_model mac (.i_clk(clk), .i_nrst(nrst), .i_frame(frame), .o_tx(tx), .o_mdc(mdc),
        .o_mdio_low(mac_low), .o_done(done));
    rps_top uut (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_mode_50mhz(mode),
        .i_addr_strap_bit0(s.phy_addr[0]), .i_addr_strap_bit1(s.phy_addr[1]), .i_cfg_strap_bit0(s.cfg_bit0),
        .i_rxd1_in(d1e ? d1o : s.phy_addr[2]), .o_rxd1_out(d1o), .o_rxd1_oe(d1e),
        .i_rxd0_in(d0e ? d0o : s.duplex), .o_rxd0_out(d0o), .o_rxd0_oe(d0e),
        .i_crs_dv_in(cre ? cro : s.cfg_bit2), .o_crs_dv_out(cro), .o_crs_dv_oe(cre),
        .i_refclk_in(rfe ? rfo : s.bcast_disable), .o_refclk_out(rfo), .o_refclk_oe(rfe),
        .i_rx_er_in(ere ? ero : s.isolate), .o_rx_er_out(ero), .o_rx_er_oe(ere),
        .i_irq_out_n_in(ire ? 1'b0 : s.nand_tree_n), .o_irq_out_n_out(iro), .o_irq_out_n_oe(ire),
        .i_rx(rx), .i_irq_req(irq), .i_tx(tx), .o_tx(txo), .i_mdc(mdc), .i_mdio_in(mdio),
        .i_mdio_drive_low(drv), .o_mdio_out(mdo), .o_mdio_oe(mde), .o_mdc_level(mdl), .o_mdc_rise(mdr),
        .o_mdio_level(mil), .o_straps(st), .o_mgmt_phy_address(addr), .o_addr0_broadcast(bc),
        .o_isolate_en(iso), .o_nand_tree_en(nand_en), .o_bcr_strap_bits(bcr), .o_run(run));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_bcr(input logic i);
        return 16'(i) << rps_pkg::BCR_ISOLATE_BIT;
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk)
    begin
        if (mdr === 1'b1)
            rises++;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(97403));
        {nrst, mode, irq, drv, frame, errors, checks, rises} = '0;
        ce = 1'b1;
        s = rps_pkg::STRAPS_RST;
        rx = '0;
        repeat (12) @(posedge clk);
        for (r = 0; r < 6; r++)
        begin
            nrst <= 1'b0;
            s <= (r == 0) ? '0 : (r == 1) ? '1 : rps_pkg::rps_straps_t'($urandom);
            mode <= r[0];
            repeat (6) @(posedge clk);
            chk("oe_reset", 16'h0, {d1e, d0e, cre, rfe, ere, ire, run});
            chk("straps_reset", 16'(rps_pkg::STRAPS_RST), 16'(st));
            nrst <= 1'b1;
            for (i = 0; i < 20; i++)
            begin
                @(posedge clk);
                #1;
                if (run === 1'b1)
                    break;
            end
            if (i == 20)
                errors++;
            if (i == 20)
                wrap_up();
            chk("run_edge", 16'(rps_pkg::CAPTURE_DELAY + 1), 16'(i));
            chk("oe_run", 16'h1f, {d1e, d0e, cre, ere, rfe ^ mode});
            chk("straps", 16'(s), 16'(st));
            chk("address", 16'(s.phy_addr), 16'(addr));
            chk("bcast", 16'(!s.bcast_disable), 16'(bc));
            chk("isolate", exp_bcr(s.isolate) | 16'(s.isolate), bcr | 16'(iso));
            chk("nand", 16'(!s.nand_tree_n), 16'(nand_en));
            repeat (8)
            begin
                @(posedge clk);
                v = rps_pkg::rps_rx_t'($urandom);
                rx <= v;
                irq <= v.rx_er;
                @(posedge clk);
                #1;
                chk("rx", 16'(v), {cro, d1o, d0o, ero});
                chk("irq", {v.rx_er, 1'b0}, {ire, iro});
                chk("tx", 16'(tx), 16'(txo));
            end
            for (t = 0; t < 2; t++)
            begin
                ce <= (t == 0);
                @(posedge clk);
                #1;
                prev = rfo;
                rises = 0;
                repeat (16)
                begin
                    @(posedge clk);
                    #1;
                    rises += (rfo !== prev);
                    prev = rfo;
                end
                chk("refclk", (t == 0 && !mode) ? 16'd8 : 16'd0, 16'(rises));
            end
            ce <= 1'b1;
            held = s;
            s <= ~s;
            rises = 0;
            frame <= 1'b1;
            for (i = 0; i < 200 && done !== 1'b1; i++)
                @(posedge clk);
            if (i == 200)
                errors++;
            if (i == 200)
                wrap_up();
            frame <= 1'b0;
            drv <= 1'b1;
            repeat (8) @(posedge clk);
            chk("mdc_rises", 16'd8, 16'(rises));
            chk("mdio_low", 16'h2, {mdl, mde, mil});
            chk("straps_hold", 16'(held), 16'(st));
            drv <= 1'b0;
            repeat (8) @(posedge clk);
            chk("mdio_idle", 16'h1, {mdl, mde, mil});
        end
        wrap_up();
    end
endmodule
`default_nettype wire
